/* File: include/sideband_pkg.sv */
package sideband_pkg;

    // Bus widths
    localparam int DATA_W = 64;
    localparam int BYTE_LANES = 8;
    localparam int IRQ_W = 4;
    localparam int PAR_CTRL_W = 2;

    // Interrupt level codes
    localparam logic [3:0] IRQ_NONE = 4'h0;
    localparam logic [3:0] IRQ_MASK_MIN = 4'h1;
    localparam logic [3:0] IRQ_MASK_MAX = 4'hE;
    localparam logic [3:0] IRQ_NMI = 4'hF;

    // Parity control reset value (parity off)
    localparam logic [1:0] PAR_CTRL_RESET = 2'h0;

    // Operation requested by the core for a master command cycle
    typedef enum logic [2:0] {
        OP_LOAD,
        OP_STORE,
        OP_LOAD_STORE_UBYTE,
        OP_LOAD_STORE_UBYTE_ALT,
        OP_SWAP,
        OP_SWAP_ALT,
        OP_DEMAP
    } cmd_op_t;

    // Active-low qualifiers that travel with the command strobe
    typedef struct packed {
        logic strobe_n;
        logic flush_n;
        logic rd_n;
        logic wr_n;
        logic atomic_n;
    } bus_qual_t;

    localparam bus_qual_t QUAL_IDLE = 5'h1F;

    // Decoded interrupt request toward the core
    typedef struct packed {
        logic req;
        logic nmi;
        logic [3:0] level;
    } irq_req_t;

    localparam irq_req_t IRQ_IDLE = 6'h00;

endpackage

/* File: hw/byte_parity_unit.sv */
`timescale 1ns/1ns
module byte_parity_unit #(
    parameter int LANES = 8
) (
    // Outgoing data and polarity
    input wire logic [LANES*8-1:0] out_data_in,
    input wire logic even_in,
    // Incoming data and parity
    input wire logic [LANES*8-1:0] in_data_in,
    input wire logic [LANES-1:0] in_parity_in,
    // Results
    output logic [LANES-1:0] gen_out,
    output logic [LANES-1:0] mismatch_out
);

    // Parity bit that makes the lane plus bit even (or odd)
    function automatic logic lane_parity(input logic [7:0] lane,
                                         input logic even);
        lane_parity = even ? ^lane : ~^lane;
    endfunction

    // Bit 0 covers the most significant lane
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            gen_out[i] = lane_parity(out_data_in[(LANES-1-i)*8 +: 8],
                                     even_in);
            mismatch_out[i] = in_parity_in[i] !=
                lane_parity(in_data_in[(LANES-1-i)*8 +: 8], 1'b1);
        end
    end

endmodule

/* File: hw/bus_sideband.sv */
`timescale 1ns/1ns
module bus_sideband #(
    parameter int DATA_W = sideband_pkg::DATA_W,
    parameter int LANES = sideband_pkg::BYTE_LANES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Core command side
    input wire logic master_in,
    input wire logic cmd_start_in,
    input wire sideband_pkg::cmd_op_t cmd_op_in,
    // Parity control bits and data path
    input wire logic [sideband_pkg::PAR_CTRL_W-1:0] parity_ctrl_in,
    input wire logic data_drive_in,
    input wire logic [DATA_W-1:0] data_out_in,
    input wire logic data_sample_in,
    input wire logic [DATA_W-1:0] data_pin_in,
    // Core status
    input wire logic error_mode_in,
    input wire logic breakpoint_event_in,
    input wire logic traps_enabled_in,
    input wire logic [3:0] pil_in,
    // Command strobe pin
    input wire logic command_strobe_n_in,
    output logic command_strobe_n_out,
    output logic command_strobe_oe_n_out,
    // TLB flush qualifier pin
    input wire logic tlb_flush_n_in,
    output logic tlb_flush_n_out,
    output logic tlb_flush_oe_n_out,
    // Byte parity pins
    input wire logic [LANES-1:0] byte_parity_in,
    output logic [LANES-1:0] byte_parity_out,
    output logic byte_parity_oe_n_out,
    // Command qualifiers
    output logic rd_n_out,
    output logic wr_n_out,
    output logic atomic_rmw_flag_n_out,
    // Status pins
    output logic error_n_out,
    output logic exec_breakpoint_strobe_out,
    input wire logic [3:0] irq_level_in,
    // Toward the core
    output logic snoop_start_out,
    output logic demap_req_out,
    output logic [LANES-1:0] parity_error_out,
    output logic irq_req_out,
    output logic irq_nmi_out,
    output logic [3:0] irq_level_out
);

    sideband_pkg::bus_qual_t qual_reg;
    sideband_pkg::bus_qual_t qual_next;
    sideband_pkg::irq_req_t irq_reg;
    sideband_pkg::irq_req_t irq_next;
    logic oe_n_reg;
    logic [LANES-1:0] par_reg;
    logic par_oe_n_reg;
    logic [LANES-1:0] perr_reg;
    logic error_n_reg;
    logic bp_reg;
    logic snoop_reg;
    logic demap_reg;
    logic parity_on;
    logic [LANES-1:0] gen_parity;
    logic [LANES-1:0] mismatch;

    // Qualifier encoding for one command word
    function automatic sideband_pkg::bus_qual_t encode_op(
        input sideband_pkg::cmd_op_t op);
        logic atomic;
        logic rd;
        logic wr;
        atomic = op inside {sideband_pkg::OP_LOAD_STORE_UBYTE,
                            sideband_pkg::OP_LOAD_STORE_UBYTE_ALT,
                            sideband_pkg::OP_SWAP,
                            sideband_pkg::OP_SWAP_ALT};
        rd = atomic || op == sideband_pkg::OP_LOAD
             || op == sideband_pkg::OP_DEMAP;
        wr = atomic || op == sideband_pkg::OP_STORE;
        encode_op.strobe_n = 1'b0;
        encode_op.flush_n = op != sideband_pkg::OP_DEMAP;
        encode_op.rd_n = !rd;
        encode_op.wr_n = !wr;
        encode_op.atomic_n = !rd || !wr;
    endfunction

    // Any set parity bit turns checking on
    assign parity_on = |parity_ctrl_in;

    byte_parity_unit #(
        .LANES(LANES)
    ) u_parity (
        .out_data_in(data_out_in),
        .even_in(parity_on),
        .in_data_in(data_pin_in),
        .in_parity_in(byte_parity_in),
        .gen_out(gen_parity),
        .mismatch_out(mismatch)
    );

    // Command word lasts exactly one cycle
    always_comb begin
        qual_next = sideband_pkg::QUAL_IDLE;
        if (master_in && cmd_start_in) begin
            qual_next = encode_op(cmd_op_in);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            qual_reg <= sideband_pkg::QUAL_IDLE;
        end else begin
            qual_reg <= qual_next;
        end
    end

    // Pins released while another party owns the bus
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= !master_in;
        end
    end

    // Incoming strobe only counts when not master
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            snoop_reg <= 1'b0;
            demap_reg <= 1'b0;
        end else begin
            snoop_reg <= !master_in && !command_strobe_n_in;
            demap_reg <= !master_in && !command_strobe_n_in
                         && !tlb_flush_n_in;
        end
    end

    // Parity driven only with data_drive_in; odd polarity when disabled
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            par_reg <= '1;
            par_oe_n_reg <= 1'b1;
        end else begin
            par_reg <= gen_parity;
            par_oe_n_reg <= !data_drive_in;
        end
    end

    // Errors reported only while enabled
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            perr_reg <= '0;
        end else if (parity_on && data_sample_in) begin
            perr_reg <= mismatch;
        end else begin
            perr_reg <= '0;
        end
    end

    // Error mode holds until the watchdog reset
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            error_n_reg <= 1'b1;
        end else if (error_mode_in) begin
            error_n_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            bp_reg <= 1'b0;
        end else begin
            bp_reg <= breakpoint_event_in;
        end
    end

    // Pending level is already prioritised by the source
    always_comb begin
        irq_next = sideband_pkg::IRQ_IDLE;
        irq_next.level = irq_level_in;
        if (irq_level_in == sideband_pkg::IRQ_NMI) begin
            irq_next.req = 1'b1;
            irq_next.nmi = 1'b1;
        end else if (irq_level_in >= sideband_pkg::IRQ_MASK_MIN
                     && irq_level_in <= sideband_pkg::IRQ_MASK_MAX) begin
            irq_next.req = traps_enabled_in && irq_level_in > pil_in;
        end else begin
            irq_next.req = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            irq_reg <= sideband_pkg::IRQ_IDLE;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign command_strobe_n_out = qual_reg.strobe_n;
    assign command_strobe_oe_n_out = oe_n_reg;
    assign tlb_flush_n_out = qual_reg.flush_n;
    assign tlb_flush_oe_n_out = oe_n_reg;
    assign rd_n_out = qual_reg.rd_n;
    assign wr_n_out = qual_reg.wr_n;
    assign atomic_rmw_flag_n_out = qual_reg.atomic_n;
    assign byte_parity_out = par_reg;
    assign byte_parity_oe_n_out = par_oe_n_reg;
    assign parity_error_out = perr_reg;
    assign error_n_out = error_n_reg;
    assign exec_breakpoint_strobe_out = bp_reg;
    assign snoop_start_out = snoop_reg;
    assign demap_req_out = demap_reg;
    assign irq_req_out = irq_reg.req;
    assign irq_nmi_out = irq_reg.nmi;
    assign irq_level_out = irq_reg.level;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_master_op(sideband_pkg::cmd_op_t op);
        master_in && cmd_start_in && cmd_op_in == op;
    endsequence

    // Back-to-back words keep the strobe low
    sequence s_cmd_word;
        !command_strobe_n_out
            ##1 (command_strobe_n_out || $past(master_in && cmd_start_in));
    endsequence

    sequence s_ext_demap;
        !master_in && !command_strobe_n_in && !tlb_flush_n_in;
    endsequence

    a_demap_cmd_word: assert property (
        s_master_op(sideband_pkg::OP_DEMAP) |=>
            !tlb_flush_n_out && !rd_n_out ##0 s_cmd_word)
        else $error("demap command word not issued");

    a_flush_idle_high: assert property (
        command_strobe_n_out |-> tlb_flush_n_out)
        else $error("flush qualifier low outside command");

    a_ext_demap_seen: assert property (
        s_ext_demap |=> demap_req_out && snoop_start_out)
        else $error("external demap not reported");

    a_master_no_snoop: assert property (
        master_in |=> !snoop_start_out && !demap_req_out)
        else $error("snoop reported while master");

    a_even_top_lane: assert property (
        parity_on |=>
            !(^{byte_parity_out[0], $past(data_out_in[DATA_W-1 -: 8])}))
        else $error("top lane parity not even");

    a_odd_low_lane: assert property (
        !parity_on |=> ^{byte_parity_out[LANES-1], $past(data_out_in[7:0])})
        else $error("low lane parity not odd");

    a_check_even_low: assert property (
        parity_on && data_sample_in
            && ^{byte_parity_in[LANES-1], data_pin_in[7:0]}
            |=> parity_error_out[LANES-1])
        else $error("low lane parity error missed");

    a_no_check_off: assert property (
        !parity_on |=> parity_error_out == '0)
        else $error("parity checked while disabled");

    a_error_sticky: assert property (
        error_mode_in |=> !error_n_out [*3])
        else $error("error output not held low");

    a_breakpoint_follow: assert property (
        breakpoint_event_in != $past(breakpoint_event_in)
            |=> exec_breakpoint_strobe_out == $past(breakpoint_event_in))
        else $error("breakpoint strobe out of step");

    a_irq_none_idle: assert property (
        irq_level_in == sideband_pkg::IRQ_NONE |=> !irq_req_out)
        else $error("request with no pending level");

    a_irq_nmi_taken: assert property (
        irq_level_in == sideband_pkg::IRQ_NMI && !traps_enabled_in
            |=> irq_req_out && irq_nmi_out)
        else $error("non-maskable level not taken");

    a_irq_masked: assert property (
        irq_level_in != sideband_pkg::IRQ_NMI
            && (!traps_enabled_in || irq_level_in <= pil_in)
            |=> !irq_req_out && !irq_nmi_out)
        else $error("masked level taken");

    a_atomic_swap_low: assert property (
        s_master_op(sideband_pkg::OP_SWAP_ALT)
            or s_master_op(sideband_pkg::OP_LOAD_STORE_UBYTE)
            |=> !atomic_rmw_flag_n_out
                ##1 (atomic_rmw_flag_n_out
                     || $past(master_in && cmd_start_in)))
        else $error("atomic flag not pulsed");

    a_atomic_or_rdwr: assert property (
        atomic_rmw_flag_n_out == (rd_n_out || wr_n_out))
        else $error("atomic flag not OR of qualifiers");

endmodule

/* File: test/cache_side_model.sv */
`timescale 1ns/1ns
module cache_side_model (
    // Clock, reset and grant
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic master_in,
    // Bench requests
    input wire logic snoop_in,
    input wire logic demap_in,
    input wire logic valid_in,
    input wire logic [63:0] data_in,
    input wire logic [7:0] corrupt_in,
    // Device pins as driven by the device
    input wire logic dev_strobe_n_in,
    input wire logic dev_flush_n_in,
    // Pins toward the device
    output logic command_strobe_n_out,
    output logic tlb_flush_n_out,
    output logic [63:0] data_out,
    output logic [7:0] byte_parity_out,
    output logic [31:0] demap_count_out
);
    logic [63:0] idle_data_reg;
    logic [7:0] idle_par_reg;
    logic [7:0] even_par;
    // Only snoops without the grant; released pins rest high
    assign command_strobe_n_out = !(snoop_in && !master_in);
    assign tlb_flush_n_out = !(snoop_in && demap_in && !master_in);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            even_par[i] = ^data_in[63-8*i -: 8];
        end
    end
    // Undriven lines toggle so stale data never looks valid
    assign data_out = valid_in ? data_in : idle_data_reg;
    assign byte_parity_out = valid_in ? even_par ^ corrupt_in : idle_par_reg;
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            idle_data_reg <= 64'h5A5A_0F0F_3C3C_9696;
            idle_par_reg <= 8'hA5;
        end else begin
            idle_data_reg <= ~data_out;
            idle_par_reg <= ~byte_parity_out;
        end
    end
    // Device demap commands are counted
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            demap_count_out <= 32'h0;
        end else if (!dev_strobe_n_in && !dev_flush_n_in) begin
            demap_count_out <= demap_count_out + 32'h1;
        end
    end
endmodule

/* File: test/tb_proc_bus_sideband_signals.sv */
`timescale 1ns/1ns
module tb_proc_bus_sideband_signals;
    typedef struct packed {
        logic [31:0] due;
        logic [2:0] kind;
        logic [63:0] val;
    } note_t;
    note_t notes_q[$];
    logic clock_in, reset_n_in, master_in, cmd_start_in, data_drive_in;
    logic data_sample_in, error_mode_in, breakpoint_event_in;
    logic traps_enabled_in, snoop, demap, last_cmd;
    sideband_pkg::cmd_op_t cmd_op_in;
    logic [1:0] parity_ctrl_in;
    logic [63:0] data_out_in, rx_data, data_pin_in;
    logic [3:0] pil_in, irq_level_in, irq_level_out;
    logic [7:0] corrupt, byte_parity_in, byte_parity_out, parity_error_out;
    logic strobe_n_out, strobe_oe_n, flush_n_out, flush_oe_n, par_oe_n;
    logic rd_n_out, wr_n_out, atomic_n, error_n_out, bkpt_out;
    logic snoop_start_out, demap_req_out, irq_req_out, irq_nmi_out;
    logic model_strobe_n, model_flush_n;
    logic [31:0] cyc, demap_count, miscompares, checked, exp_demaps;
    // Open-drain style: low from either party wins
    wire strobe_wire = (strobe_oe_n | strobe_n_out) & model_strobe_n;
    wire flush_wire = (flush_oe_n | flush_n_out) & model_flush_n;

    bus_sideband DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .master_in(master_in), .cmd_start_in(cmd_start_in),
        .cmd_op_in(cmd_op_in), .parity_ctrl_in(parity_ctrl_in),
        .data_drive_in(data_drive_in), .data_out_in(data_out_in),
        .data_sample_in(data_sample_in), .data_pin_in(data_pin_in),
        .error_mode_in(error_mode_in),
        .breakpoint_event_in(breakpoint_event_in),
        .traps_enabled_in(traps_enabled_in), .pil_in(pil_in),
        .command_strobe_n_in(strobe_wire),
        .command_strobe_n_out(strobe_n_out),
        .command_strobe_oe_n_out(strobe_oe_n),
        .tlb_flush_n_in(flush_wire), .tlb_flush_n_out(flush_n_out),
        .tlb_flush_oe_n_out(flush_oe_n), .byte_parity_in(byte_parity_in),
        .byte_parity_out(byte_parity_out), .byte_parity_oe_n_out(par_oe_n),
        .rd_n_out(rd_n_out), .wr_n_out(wr_n_out),
        .atomic_rmw_flag_n_out(atomic_n), .error_n_out(error_n_out),
        .exec_breakpoint_strobe_out(bkpt_out), .irq_level_in(irq_level_in),
        .snoop_start_out(snoop_start_out), .demap_req_out(demap_req_out),
        .parity_error_out(parity_error_out), .irq_req_out(irq_req_out),
        .irq_nmi_out(irq_nmi_out), .irq_level_out(irq_level_out));

    cache_side_model partner (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .master_in(master_in), .snoop_in(snoop), .demap_in(demap),
        .valid_in(data_sample_in), .data_in(rx_data), .corrupt_in(corrupt),
        .dev_strobe_n_in(strobe_oe_n | strobe_n_out),
        .dev_flush_n_in(flush_oe_n | flush_n_out),
        .command_strobe_n_out(model_strobe_n), .tlb_flush_n_out(model_flush_n),
        .data_out(data_pin_in), .byte_parity_out(byte_parity_in),
        .demap_count_out(demap_count));

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic summarize;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 32'h0 && checked != 32'h0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic compare(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic push(input logic [2:0] k, input logic [63:0] v);
        notes_q.push_back('{cyc + 32'h2, k, v});
    endtask

    function automatic logic [7:0] par_of(input logic [63:0] d, input logic en);
        logic [7:0] p;
        for (int i = 0; i < 8; i++) begin
            p[i] = (^d[63-8*i -: 8]) ^ !en;
        end
        return p;
    endfunction

    // Hang guard: the run needs well under a thousand cycles
    always @(posedge clock_in) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd1000) begin
            miscompares++;
            summarize();
        end
    end

    always @(negedge clock_in) begin
        note_t n;
        while (notes_q.size() > 0 && notes_q[0].due == cyc) begin
            n = notes_q.pop_front();
            case (n.kind)
                3'h0: compare(64'({strobe_oe_n, flush_oe_n, strobe_n_out,
                    flush_n_out, rd_n_out, wr_n_out, atomic_n}),
                    n.val);
                3'h1: compare(64'({snoop_start_out, demap_req_out}), n.val);
                3'h2: compare(64'({par_oe_n, byte_parity_out}), n.val);
                3'h3: compare(64'(parity_error_out), n.val);
                3'h4: compare(64'({irq_req_out, irq_nmi_out,
                    irq_level_out}), n.val);
                default: compare(64'({error_n_out, bkpt_out}), n.val);
            endcase
        end
    end

    task automatic drive_cycle(input int i);
        logic m, s, sn, dm, dr, sa, tr, bk, at, rl, wl;
        logic [1:0] pc;
        logic [3:0] pl, lv;
        logic [7:0] cr;
        logic [4:0] q;
        logic [31:0] r;
        logic [63:0] dd, rx;
        sideband_pkg::cmd_op_t op;
        r = $urandom();
        {m, s, sn, dm, dr, sa, tr, bk, pc, pl, cr} = r[21:0];
        dd = {$urandom(), $urandom()};
        rx = {$urandom(), $urandom()};
        op = sideband_pkg::cmd_op_t'(i % 7);
        lv = 4'(i);
        // Grant stays while our own strobe is on the pin
        m = m | last_cmd;
        last_cmd = m & s;
        at = op inside {[sideband_pkg::OP_LOAD_STORE_UBYTE:
                         sideband_pkg::OP_SWAP_ALT]};
        rl = at || op == sideband_pkg::OP_LOAD || op == sideband_pkg::OP_DEMAP;
        wl = at || op == sideband_pkg::OP_STORE;
        @(posedge clock_in);
        master_in <= m;
        cmd_start_in <= s;
        cmd_op_in <= op;
        snoop <= sn;
        demap <= dm;
        data_drive_in <= dr;
        data_out_in <= dd;
        data_sample_in <= sa;
        rx_data <= rx;
        corrupt <= cr;
        parity_ctrl_in <= pc;
        traps_enabled_in <= tr;
        pil_in <= pl;
        irq_level_in <= lv;
        breakpoint_event_in <= bk;
        q = sideband_pkg::QUAL_IDLE;
        if (m && s) begin
            q = {1'b0, op != sideband_pkg::OP_DEMAP, !rl, !wl, !rl | !wl};
            exp_demaps += 32'(op == sideband_pkg::OP_DEMAP);
        end
        // Pins released whenever the grant is away
        push(3'h0, 64'({!m, !m, q}));
        push(3'h1, 64'({sn && !m, sn && dm && !m}));
        push(3'h2, 64'({!dr, par_of(dd, |pc)}));
        push(3'h3, 64'((sa && |pc) ? cr : 8'h0));
        r[0] = lv == 4'hF || (lv != 4'h0 && tr && lv > pl);
        push(3'h4, 64'({r[0], lv == 4'hF, lv}));
        push(3'h5, 64'({1'b1, bk}));
    endtask

    initial begin
        {reset_n_in, master_in, cmd_start_in, data_drive_in} = 4'h0;
        {data_sample_in, error_mode_in, breakpoint_event_in} = 3'h0;
        {traps_enabled_in, snoop, demap, last_cmd} = 4'h0;
        cmd_op_in = sideband_pkg::OP_LOAD;
        {parity_ctrl_in, pil_in, irq_level_in, corrupt} = 18'h0;
        {data_out_in, rx_data} = 128'h0;
        {cyc, miscompares, checked, exp_demaps} = 128'h0;
        void'($urandom(32'h7E00));
        repeat (8) @(posedge clock_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        for (int i = 0; i < 320; i++) begin
            drive_cycle(i);
        end
        @(posedge clock_in);
        {master_in, cmd_start_in, snoop, data_sample_in} <= 4'h0;
        breakpoint_event_in <= 1'b0;
        error_mode_in <= 1'b1;
        push(3'h5, 64'h0);
        // Error output must hold low after the cause goes away
        repeat (4) begin
            @(posedge clock_in);
            error_mode_in <= 1'b0;
            push(3'h5, 64'h0);
        end
        repeat (3) @(posedge clock_in);
        compare(64'(demap_count), 64'(exp_demaps));
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        push(3'h5, 64'h2);
        repeat (4) @(posedge clock_in);
        summarize();
    end
endmodule
